// *** dwrs_sequencer.sv ***
`include "dwrs_regs.svh"
module dwrs_sequencer
  import dwrs_pkg::*;
#(
  parameter int BURST_MAX = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_half_rate_phase,
  input wire logic i_write_req,
  input wire logic i_page_mode,
  input wire logic i_keep_page,
  input wire logic i_refresh_req,
  input wire logic i_alt_group,
  input wire logic [`DWRS_ROW_W-1:0] i_bank_select,
  input wire logic [$clog2(BURST_MAX+1)-1:0] i_burst_len,
  input wire dwrs_timing_type i_timing,
  input wire dwrs_addr_type i_addr,
  output logic [`DWRS_ADDR_W-1:0] o_dram_mux_address,
  output logic [`DWRS_ROW_W-1:0] o_row_strobe_n,
  output logic [`DWRS_ROW_W-1:0] o_alt_row_strobe_n,
  output logic [`DWRS_COL_STROBES-1:0] o_column_strobe_n,
  output logic [`DWRS_WE_W-1:0] o_dram_write_enable_n,
  output logic [`DWRS_CMD_W-1:0] o_datapath_command,
  output logic o_busy,
  output logic o_done
);
  localparam int BW = $clog2(BURST_MAX+1);

  if (BURST_MAX < 1) begin : g_burst_check
    $error("burst length must be at least one");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {i_half_rate_phase, i_write_req, i_refresh_req, i_page_mode};
      sync2_q <= sync1_q;
    end
  end
  logic phase_s;
  logic write_s;
  logic refresh_s;
  logic page_s;
  assign {phase_s, write_s, refresh_s, page_s} = sync2_q;

  // ---------------------------------------------------------------
  // state and counter
  // ---------------------------------------------------------------
  dwrs_state_type state_q;
  dwrs_state_type state_d;
  logic cnt_load;
  logic [`DWRS_CNT_W-1:0] cnt_value;
  logic cnt_done;
  logic [BW-1:0] beats_q;
  logic [`DWRS_CNT_W-1:0] chold_q;
  logic [`DWRS_CNT_W-1:0] prech_q;
  logic row_open_q;
  logic is_refresh_q;
  logic alt_q;
  logic [`DWRS_ROW_W-1:0] bank_q;
  logic last_beat;
  logic start_ok;

  dwrs_down_counter #(.WIDTH(`DWRS_CNT_W)) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(cnt_load),
    .i_value(cnt_value),
    .o_done(cnt_done)
  );

  assign last_beat = (beats_q <= BW'(1));
  assign start_ok = phase_s && (prech_q == '0);

  always_comb begin
    state_d = state_q;
    cnt_load = 1'b0;
    cnt_value = '0;
    case (state_q)
      DWRS_IDLE: begin
        if (start_ok && refresh_s) begin
          state_d = DWRS_REF_GAP;
          cnt_load = 1'b1;
          cnt_value = i_timing.refresh_strobe_gap;
        end else if (start_ok && write_s) begin
          state_d = (page_s && row_open_q) ? DWRS_PAGE_LOAD : DWRS_ROW_LOAD;
        end
      end
      DWRS_ROW_LOAD: begin
        state_d = DWRS_ROW_SETUP;
        cnt_load = 1'b1;
        cnt_value = i_timing.row_setup_cycles;
      end
      DWRS_ROW_SETUP: begin
        if (cnt_done) begin
          state_d = DWRS_ROW_HOLD;
          cnt_load = 1'b1;
          cnt_value = i_timing.row_hold_cycles;
        end
      end
      DWRS_ROW_HOLD: begin
        if (cnt_done) begin
          state_d = DWRS_COL_SETUP;
          cnt_load = 1'b1;
          cnt_value = i_timing.column_setup_cycles;
        end
      end
      DWRS_PAGE_LOAD: begin
        state_d = DWRS_COL_SETUP;
        cnt_load = 1'b1;
        cnt_value = i_timing.column_setup_cycles;
      end
      DWRS_COL_SETUP: begin
        if (cnt_done) begin
          state_d = DWRS_COL_PULSE;
          cnt_load = 1'b1;
          cnt_value = i_timing.write_strobe_width + `DWRS_CNT_W'(1);
        end
      end
      DWRS_COL_PULSE: begin
        if (cnt_done) begin
          state_d = last_beat ? DWRS_IDLE : DWRS_COL_PRECH;
          cnt_load = !last_beat;
          cnt_value = i_timing.cas_precharge_cycles;
        end
      end
      DWRS_COL_PRECH: begin
        if (cnt_done) begin
          state_d = DWRS_COL_PULSE;
          cnt_load = 1'b1;
          cnt_value = i_timing.write_strobe_width + `DWRS_CNT_W'(1);
        end
      end
      DWRS_REF_GAP: begin
        if (cnt_done) begin
          state_d = DWRS_REF_ROW;
          cnt_load = 1'b1;
          cnt_value = i_timing.refresh_row_pulse_width + `DWRS_CNT_W'(1);
        end
      end
      DWRS_REF_ROW: begin
        if (cnt_done) begin
          state_d = DWRS_REF_END;
        end
      end
      DWRS_REF_END: begin
        state_d = DWRS_IDLE;
      end
      default: begin
        state_d = DWRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= DWRS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // per-transaction context
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      beats_q <= '0;
      alt_q <= 1'b0;
      bank_q <= '0;
      is_refresh_q <= 1'b0;
    end else if (state_q == DWRS_IDLE && state_d != DWRS_IDLE) begin
      beats_q <= (i_burst_len == '0) ? BW'(1) : i_burst_len;
      alt_q <= i_alt_group;
      bank_q <= i_bank_select;
      is_refresh_q <= refresh_s;
    end else if (state_q == DWRS_COL_PULSE && cnt_done && !last_beat) begin
      beats_q <= beats_q - BW'(1);
    end
  end

  // row precharge counter, started as refresh row strobes release
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prech_q <= '0;
    end else if (state_q == DWRS_REF_ROW && cnt_done) begin
      prech_q <= i_timing.row_precharge_cycles;
    end else if (prech_q != '0) begin
      prech_q <= prech_q - `DWRS_CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // strobes
  // ---------------------------------------------------------------
  logic burst_end;
  assign burst_end = (state_q == DWRS_COL_PULSE) && cnt_done && last_beat;
  logic page_start;
  assign page_start = (state_q == DWRS_IDLE) && (state_d == DWRS_PAGE_LOAD);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_row_strobe_n <= `DWRS_ROW_STROBE_IDLE;
      o_alt_row_strobe_n <= `DWRS_ROW_STROBE_IDLE;
      row_open_q <= 1'b0;
    end else if (state_q == DWRS_ROW_SETUP && cnt_done) begin
      o_row_strobe_n <= alt_q ? `DWRS_ROW_STROBE_IDLE : ~bank_q;
      o_alt_row_strobe_n <= alt_q ? ~bank_q : `DWRS_ROW_STROBE_IDLE;
      row_open_q <= 1'b1;
    end else if (state_q == DWRS_REF_GAP && cnt_done) begin
      o_row_strobe_n <= '0;
      o_alt_row_strobe_n <= '0;
    end else if ((state_q == DWRS_REF_ROW && cnt_done) || (burst_end && !i_keep_page)) begin
      o_row_strobe_n <= `DWRS_ROW_STROBE_IDLE;
      o_alt_row_strobe_n <= `DWRS_ROW_STROBE_IDLE;
      row_open_q <= 1'b0;
    end else if (state_q == DWRS_IDLE && start_ok && refresh_s) begin
      row_open_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_column_strobe_n <= `DWRS_COL_STROBE_IDLE;
    end else if ((state_q == DWRS_IDLE && start_ok && refresh_s)
                 || (state_q == DWRS_COL_SETUP && cnt_done)
                 || (state_q == DWRS_COL_PRECH && cnt_done)) begin
      o_column_strobe_n <= '0;
    end else if ((state_q == DWRS_COL_PULSE && cnt_done) || state_q == DWRS_REF_END) begin
      o_column_strobe_n <= `DWRS_COL_STROBE_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dram_write_enable_n <= `DWRS_WE_IDLE;
    end else if ((state_q == DWRS_ROW_HOLD && cnt_done) || page_start) begin
      o_dram_write_enable_n <= '0;
    end else if (burst_end) begin
      o_dram_write_enable_n <= `DWRS_WE_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // address multiplexer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dram_mux_address <= '0;
      chold_q <= '0;
    end else if (state_q == DWRS_IDLE && state_d == DWRS_ROW_LOAD) begin
      o_dram_mux_address <= i_addr.write_row;
    end else if ((state_q == DWRS_ROW_HOLD && cnt_done) || page_start) begin
      o_dram_mux_address <= i_addr.write_column;
    end else if (burst_end || state_q == DWRS_IDLE || is_refresh_q) begin
      o_dram_mux_address <= i_addr.read_row;
    end else if (chold_q == `DWRS_CNT_W'(1)) begin
      o_dram_mux_address <= o_dram_mux_address + `DWRS_ADDR_W'(1);
    end
    if (i_rst) begin
      chold_q <= '0;
    end else if ((state_q == DWRS_COL_SETUP || state_q == DWRS_COL_PRECH) && cnt_done) begin
      chold_q <= i_timing.column_hold_cycles + `DWRS_CNT_W'(1);
    end else if (chold_q != '0) begin
      chold_q <= chold_q - `DWRS_CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // data path command
  // ---------------------------------------------------------------
  logic strobe_on;
  assign strobe_on = (state_q == DWRS_COL_SETUP || state_q == DWRS_COL_PRECH) && cnt_done;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_datapath_command <= `DWRS_CMD_IDLE;
    end else if (strobe_on && beats_q > BW'(1)) begin
      o_datapath_command <= `DWRS_CMD_WRITE_IMMEDIATE;
    end else if (strobe_on) begin
      o_datapath_command <= `DWRS_CMD_WRITE_DELAY_LAST;
    end else if (burst_end) begin
      o_datapath_command <= `DWRS_CMD_RESET;
    end else begin
      o_datapath_command <= `DWRS_CMD_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_busy <= (state_d != DWRS_IDLE);
      o_done <= burst_end || state_q == DWRS_REF_END;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  row_after_prech_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (prech_q != '0) |=> $stable(o_row_strobe_n) || (&o_row_strobe_n))
    else $error("row strobe during precharge");
  start_on_phase_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == DWRS_IDLE && state_d != DWRS_IDLE) |-> phase_s)
    else $error("start without phase");
  we_with_column_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_dram_write_enable_n[0]) |-> o_dram_mux_address == $past(i_addr.write_column))
    else $error("enable not with column");
  end_restore_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_dram_write_enable_n[0]) |-> (&o_column_strobe_n))
    else $error("enable release mismatch");
  reset_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    burst_end |=> o_datapath_command == `DWRS_CMD_RESET)
    else $error("no reset command");
  ref_cas_after_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == DWRS_REF_ROW && cnt_done) |=> (&o_row_strobe_n) ##1 (&o_column_strobe_n))
    else $error("refresh release order");
  ref_cas_first_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_row_strobe_n[0]) && is_refresh_q |-> (o_column_strobe_n == '0))
    else $error("refresh row before column");
  row_setup_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == DWRS_ROW_LOAD && i_timing.row_setup_cycles == '0) |=> ##1
      (o_row_strobe_n != `DWRS_ROW_STROBE_IDLE || o_alt_row_strobe_n != `DWRS_ROW_STROBE_IDLE
       || bank_q == '0))
    else $error("row strobe late");
endmodule // dwrs_sequencer

// *** dwrs_regs.svh ***
`ifndef DWRS_REGS_SVH
`define DWRS_REGS_SVH

// ---------------------------------------------------------------
// datapath command encodings
// ---------------------------------------------------------------
`define DWRS_CMD_IDLE 3'h0
`define DWRS_CMD_RESET 3'h1
`define DWRS_CMD_WRITE_IMMEDIATE 3'h2
`define DWRS_CMD_WRITE_DELAY_LAST 3'h3
`define DWRS_CMD_READ_IMMEDIATE 3'h4

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define DWRS_ADDR_W 12
`define DWRS_ROW_W 9
`define DWRS_CNT_W 4
`define DWRS_COL_STROBES 4
`define DWRS_WE_W 2
`define DWRS_CMD_W 3
`define DWRS_ROW_STROBE_IDLE 9'h1ff
`define DWRS_COL_STROBE_IDLE 4'hf
`define DWRS_WE_IDLE 2'h3
// data path advances its line pointer this many cycles after last command
`define DWRS_LAST_PTR_DELAY 3

`endif

// *** dwrs_pkg.sv ***
package dwrs_pkg;
  `include "dwrs_regs.svh"

  typedef struct packed {
    logic [`DWRS_CNT_W-1:0] row_setup_cycles;
    logic [`DWRS_CNT_W-1:0] row_hold_cycles;
    logic [`DWRS_CNT_W-1:0] column_setup_cycles;
    logic [`DWRS_CNT_W-1:0] column_hold_cycles;
    logic [`DWRS_CNT_W-1:0] write_strobe_width;
    logic [`DWRS_CNT_W-1:0] cas_precharge_cycles;
    logic [`DWRS_CNT_W-1:0] refresh_strobe_gap;
    logic [`DWRS_CNT_W-1:0] refresh_row_pulse_width;
    logic [`DWRS_CNT_W-1:0] row_precharge_cycles;
  } dwrs_timing_type;

  typedef struct packed {
    logic [`DWRS_ADDR_W-1:0] read_row;
    logic [`DWRS_ADDR_W-1:0] write_row;
    logic [`DWRS_ADDR_W-1:0] write_column;
  } dwrs_addr_type;

  typedef enum logic [11:0] {
    DWRS_IDLE = 12'h001,
    DWRS_ROW_LOAD = 12'h002,
    DWRS_ROW_SETUP = 12'h004,
    DWRS_ROW_HOLD = 12'h008,
    DWRS_COL_SETUP = 12'h010,
    DWRS_COL_PULSE = 12'h020,
    DWRS_COL_PRECH = 12'h040,
    DWRS_REF_GAP = 12'h080,
    DWRS_REF_ROW = 12'h100,
    DWRS_REF_END = 12'h200,
    DWRS_PRECHARGE = 12'h400,
    DWRS_PAGE_LOAD = 12'h800
  } dwrs_state_type;
endpackage

// *** dwrs_down_counter.sv ***
// ---------------------------------------------------------------
// loadable down-counter, done when zero
// ---------------------------------------------------------------
module dwrs_down_counter #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_value,
  output logic o_done
);
  logic [WIDTH-1:0] count_q;

  if (WIDTH < 1) begin : g_width_check
    $error("counter width too small");
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= '0;
    end else if (i_load) begin
      count_q <= i_value;
    end else if (count_q != '0) begin
      count_q <= count_q - WIDTH'(1);
    end
  end

  // done depends on the count only, never on the load that it triggers
  assign o_done = (count_q == '0);
endmodule // dwrs_down_counter

// *** dwrs_dram_model.sv ***
`include "dwrs_regs.svh"
// ---------------------------------------------------------------
// data path slice model: line pointer and beat counter
// ---------------------------------------------------------------
module dwrs_dram_model
  import dwrs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [`DWRS_CMD_W-1:0] i_datapath_command,
  input wire logic [`DWRS_COL_STROBES-1:0] i_column_strobe_n,
  input wire logic [`DWRS_WE_W-1:0] i_dram_write_enable_n,
  output logic [7:0] o_line_ptr,
  output logic [3:0] o_beats
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last_q;
  logic cas_q;
  always_ff @(posedge i_clk) begin
    cas_q <= &i_column_strobe_n;
    if (i_rst || i_datapath_command == `DWRS_CMD_RESET) begin
      o_beats <= 4'h0;
    end else if (cas_q && i_column_strobe_n == 4'h0 && i_dram_write_enable_n == 2'h0) begin
      o_beats <= o_beats + 4'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_q <= 3'h0;
      o_line_ptr <= 8'h00;
    end else begin
      last_q <= {last_q[1:0], i_datapath_command == `DWRS_CMD_WRITE_DELAY_LAST};
      if (last_q[2]) begin
        o_line_ptr <= o_line_ptr + 8'h01;
      end
    end
  end
endmodule // dwrs_dram_model

// *** testbench.sv ***
`include "dwrs_regs.svh"
module testbench;
  import dwrs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst = 1, ph = 0, ph_en = 0, wr = 0, pm = 0, kp = 0, rf = 0, ag = 0;
  logic [8:0] bank = 9'h024;
  logic [2:0] bl = 3'h1;
  dwrs_timing_type tim = '0;
  dwrs_addr_type adr = {12'h3a1, 12'h5c2, 12'h0f4};
  logic [11:0] a_o;
  logic [8:0] r_o, ra_o;
  logic [3:0] c_o, beats;
  logic [1:0] we_o;
  logic [2:0] cmd_o;
  logic busy, done;
  logic [7:0] ptr;
  int err_total = 0, compares = 0, cyc = 0;
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  always @(negedge i_clk) if (ph_en) ph <= ~ph;
  dwrs_sequencer #(.BURST_MAX(4)) u_dwrs_sequencer (.i_clk(i_clk), .i_rst(i_rst),
    .i_half_rate_phase(ph), .i_write_req(wr), .i_page_mode(pm), .i_keep_page(kp),
    .i_refresh_req(rf), .i_alt_group(ag), .i_bank_select(bank), .i_burst_len(bl),
    .i_timing(tim), .i_addr(adr), .o_dram_mux_address(a_o), .o_row_strobe_n(r_o),
    .o_alt_row_strobe_n(ra_o), .o_column_strobe_n(c_o), .o_dram_write_enable_n(we_o),
    .o_datapath_command(cmd_o), .o_busy(busy), .o_done(done));
  dwrs_dram_model u_dwrs_dram_model (.i_clk(i_clk), .i_rst(i_rst),
    .i_datapath_command(cmd_o), .i_column_strobe_n(c_o), .i_dram_write_enable_n(we_o),
    .o_line_ptr(ptr), .o_beats(beats));
  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic bit cond(input int s);
    case (s)
      0: return a_o === adr.write_row;
      1: return r_o !== 9'h1ff || ra_o !== 9'h1ff;
      2: return c_o === 4'h0;
      3: return c_o === 4'hf;
      4: return busy === 1'b0;
      5: return a_o === adr.write_column;
      default: return r_o === 9'h1ff && ra_o === 9'h1ff;
    endcase
  endfunction
  task automatic wt(input int s, output int t);
    int n;
    n = 0;
    while (!cond(s) && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 300) chk("wait", 0, s + 1);
    t = cyc;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_phase_low();
    int i;
    @(negedge i_clk);
    wr = 1'b1;
    for (i = 0; i < 20; i++) @(negedge i_clk);
    chk("busy", 0, busy);
    chk("row_n", 9'h1ff, r_o);
    chk("cas_n", 4'hf, c_o);
    chk("cmd", `DWRS_CMD_IDLE, cmd_o);
    wr = 1'b0;
    @(negedge i_clk);
    @(negedge i_clk);
    $display("test phase_low done");
  endtask
  task automatic t_write(input logic [2:0] len, input logic pg, input logic keep,
                         input logic alt);
    int ta, tr, tc, tl, th, tl2, t;
    logic [7:0] p;
    logic [8:0] rn, nb;
    p = ptr;
    rn = r_o;
    nb = ~bank;
    @(negedge i_clk);
    bl = len;
    pm = pg;
    kp = keep;
    ag = alt;
    wr = 1'b1;
    if (!pg) begin
      wt(0, ta);
      wt(1, tr);
      chk("row_delay", 2 + tim.row_setup_cycles, tr - ta);
      chk("row_n", alt ? 9'h1ff : nb, r_o);
      chk("alt_n", alt ? nb : 9'h1ff, ra_o);
      wt(5, tc);
      chk("col_delay", 1 + tim.row_hold_cycles, tc - tr);
    end else begin
      wt(5, tc);
      chk("page_row_n", rn, r_o);
    end
    chk("we_n", 0, we_o);
    wt(2, tl);
    chk("cas_delay", (pg ? 2 : 1) + tim.column_setup_cycles, tl - tc);
    chk("cmd", len > 1 ? `DWRS_CMD_WRITE_IMMEDIATE : `DWRS_CMD_WRITE_DELAY_LAST, cmd_o);
    if (len == 1) wr = 1'b0;
    wt(3, th);
    chk("cas_width", 2 + tim.write_strobe_width, th - tl);
    if (len > 1) begin
      chk("we_hold", 0, we_o);
      wt(2, tl2);
      wr = 1'b0;
      chk("cas_gap", 1 + tim.cas_precharge_cycles, tl2 - th);
      chk("next_col", adr.write_column + 12'h001, a_o);
      chk("cmd_last", `DWRS_CMD_WRITE_DELAY_LAST, cmd_o);
      wt(3, th);
    end
    chk("we_end", 2'h3, we_o);
    chk("addr_end", adr.read_row, a_o);
    chk("row_end", keep ? (alt ? 9'h1ff : nb) : 9'h1ff, r_o);
    chk("cmd_reset", `DWRS_CMD_RESET, cmd_o);
    chk("done", 1, done);
    chk("beats_len", len, beats);
    wt(4, t);
    @(negedge i_clk);
    @(negedge i_clk);
    chk("line_ptr", p + 8'h01, ptr);
    chk("beats", 0, beats);
    $display("test write done");
  endtask
  task automatic t_refresh();
    int tc, tr, th, tn, t;
    @(negedge i_clk);
    kp = 1'b0;
    pm = 1'b0;
    bl = 3'h1;
    rf = 1'b1;
    wr = 1'b1;
    wt(2, tc);
    rf = 1'b0;
    chk("ref_addr", adr.read_row, a_o);
    chk("ref_rows_off", 9'h1ff, r_o);
    wt(1, tr);
    chk("ref_gap", 1 + tim.refresh_strobe_gap, tr - tc);
    chk("ref_rows", 0, r_o);
    chk("ref_alt", 0, ra_o);
    wt(6, th);
    chk("ref_width", 2 + tim.refresh_row_pulse_width, th - tr);
    chk("ref_cas_low", 4'h0, c_o);
    @(negedge i_clk);
    chk("ref_cas_high", 4'hf, c_o);
    chk("ref_done", 1, done);
    wt(1, tn);
    wr = 1'b0;
    chk("precharge", 1, (tn - th) > tim.row_precharge_cycles);
    wt(4, t);
    $display("test refresh done");
  endtask
  initial begin
    #200us;
    err_total++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    repeat (12) @(negedge i_clk);
    i_rst = 1'b0;
    t_phase_low();
    ph_en = 1'b1;
    tim = {4'h1, 4'h2, 4'h1, 4'h1, 4'h1, 4'h2, 4'h1, 4'h1, 4'h3};
    t_write(3'h2, 1'b0, 1'b1, 1'b0);
    t_write(3'h1, 1'b1, 1'b0, 1'b0);
    tim = '0;
    bank = 9'h101;
    t_write(3'h1, 1'b0, 1'b0, 1'b1);
    tim = {4'h1, 4'h2, 4'h1, 4'h1, 4'h1, 4'h2, 4'h1, 4'h1, 4'h3};
    t_refresh();
    test_done();
  end
endmodule // testbench
